// file: fspc_pkg.sv
// shared constants for the flash self-programming controller
package fspc_pkg;
  // sector numbers of the cpu data-memory space
  localparam logic [7:0] FSPC_CTRL_SECTOR  = 8'h01;
  localparam logic [7:0] FSPC_DATA_SECTOR  = 8'h00;
  // control registers in the control sector
  localparam logic [7:0] FSPC_MAIN_CTRL    = 8'h43;
  localparam logic [7:0] FSPC_RST_PATTERN  = 8'h44;
  localparam logic [7:0] FSPC_BUF_CLR_CTRL = 8'h45;
  // address and data registers in the data sector
  localparam logic [7:0] FSPC_ADDR_LO      = 8'h40;
  localparam logic [7:0] FSPC_ADDR_HI      = 8'h41;
  localparam logic [7:0] FSPC_DATA0_LO     = 8'h42;
  localparam logic [7:0] FSPC_DATA0_HI     = 8'h43;
  localparam logic [7:0] FSPC_DATA1_LO     = 8'h44;
  localparam logic [7:0] FSPC_DATA3_HI     = 8'h49;
  // main control and buffer clear field positions
  localparam int FSPC_STATUS_BIT  = 7;
  localparam int FSPC_MODE_HI     = 6;
  localparam int FSPC_MODE_LO     = 4;
  localparam int FSPC_PROC_BIT    = 3;
  localparam int FSPC_WSTART_BIT  = 2;
  localparam int FSPC_RPERMIT_BIT = 1;
  localparam int FSPC_RSTART_BIT  = 0;
  localparam int FSPC_BUFCLR_BIT  = 0;
  // operation mode codes
  localparam logic [2:0] FSPC_MODE_WRITE  = 3'h0;
  localparam logic [2:0] FSPC_MODE_ERASE  = 3'h1;
  localparam logic [2:0] FSPC_MODE_READ   = 3'h3;
  localparam logic [2:0] FSPC_MODE_UNLOCK = 3'h6;
  // reset values and special patterns
  localparam logic [7:0]  FSPC_REG_RESET  = 8'h00;
  localparam logic [15:0] FSPC_WORD_RESET = 16'h0000;
  localparam logic [7:0]  FSPC_CHIP_RESET_KEY = 8'h55;
  localparam int          FSPC_UNLOCK_LEN = 6;
  localparam logic [7:0]  FSPC_UNLOCK_PAT [0:5] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  localparam int          FSPC_UNLOCK_TIMEOUT_US = 300;
  // flash array commands
  localparam logic [1:0] FSPC_FL_WRITE = 2'h0;
  localparam logic [1:0] FSPC_FL_ERASE = 2'h1;
  localparam logic [1:0] FSPC_FL_READ  = 2'h2;
  // no-target code for the unlock write index
  localparam logic [2:0] FSPC_NO_IDX = 3'h7;
endpackage

// file: fspc_unlock.sv
// unlock pattern checker with slow-oscillator timeout
`timescale 1ns/1ps
module fspc_unlock #(
  parameter int SLOW_OSC_KHZ = 32
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       arm,
  input  wire logic       slow_tick,
  // data register writes
  input  wire logic       wr_stb,
  input  wire logic [2:0] wr_idx,
  input  wire logic [7:0] wr_data,
  // result
  output logic            done,
  output logic            ok
);
  import fspc_pkg::*;
  // longest time rounds down, never below one tick
  localparam int TICKS_RAW = FSPC_UNLOCK_TIMEOUT_US * SLOW_OSC_KHZ / 1000;
  localparam int TICKS = (TICKS_RAW < 1) ? 1 : TICKS_RAW;
  localparam logic [15:0] TICKS_W = 16'(TICKS);
  if (SLOW_OSC_KHZ < 1 || TICKS > 65535) begin : g_chk
    $error("fspc_unlock: unsupported slow oscillator rate");
  end

  logic        active_reg;
  logic [2:0]  step_reg;
  logic [15:0] tick_reg;

  // sequence tracking; any wrong write to the pattern registers or a timeout ends the attempt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      step_reg   <= 3'h0;
      tick_reg   <= 16'h0000;
      done       <= 1'b0;
      ok         <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!active_reg) begin
        if (arm && !done) begin
          active_reg <= 1'b1;
          step_reg   <= 3'h0;
          tick_reg   <= 16'h0000;
        end
      end else if (wr_stb && wr_idx != FSPC_NO_IDX) begin
        if (wr_idx == step_reg && wr_data == FSPC_UNLOCK_PAT[step_reg]) begin // RL19
          step_reg <= step_reg + 3'h1;
          if (step_reg == 3'(FSPC_UNLOCK_LEN - 1)) begin
            active_reg <= 1'b0;
            done       <= 1'b1;
            ok         <= 1'b1;
          end
        end else begin
          active_reg <= 1'b0; // RL20
          done       <= 1'b1;
          ok         <= 1'b0;
        end
      end else if (slow_tick) begin
        if (tick_reg == TICKS_W - 16'h0001) begin
          active_reg <= 1'b0; // RL19
          done       <= 1'b1;
          ok         <= 1'b0;
        end else begin
          tick_reg <= tick_reg + 16'h0001;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_done_pulse;
    done |=> !done && !active_reg;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("unlock done not a pulse"); // RL20

  property p_wrong_fails;
    active_reg && wr_stb && wr_idx != FSPC_NO_IDX && wr_idx != step_reg |=> done && !ok;
  endproperty
  a_wrong_fails: assert property (p_wrong_fails) else $error("wrong pattern accepted"); // RL19
endmodule

// file: fspc_ctrl.sv
// flash self-programming control registers and sequencer
// Summary of operation
// RL1 - control registers at 43h-45h of sector one
// RL2 - software uses pointer pairs two or three
// RL3 - clearing status bit disables writing immediately
// RL4 - software writing one to status ignored
// RL5 - hardware sets status only on unlock success
// RL6 - mode field decodes write, erase, read, unlock
// RL7 - procedure bit plus unlock mode runs unlock
// RL8 - procedure bit not needed after unlocking
// RL9 - write start cleared when write finishes
// RL10 - read permit bit gates flash reads
// RL11 - read start cleared when read completes
// RL12 - writing 55h to reset register resets chip
// RL13 - buffer clear bit self-clears after clearing
// RL14 - buffer clear register upper bits read zero
// RL15 - thirteen-bit variant: high bits 7-5 zero
// RL16 - fourteen-bit variant: high bits 7-6 zero
// RL17 - page and burst 32/64/128, reads single
// RL18 - first data high write loads, increments address
// RL19 - six-byte unlock pattern within 300 us
// RL20 - unlock end always clears procedure bit; a main register write in the same cycle wins here
// RL21 - reserved mode starts no flash operation
// RL22 - address width parameter 13 to 16 bits
`timescale 1ns/1ps
module fspc_ctrl #(
  parameter int ADDR_BITS      = 13,
  parameter int WORDS_PER_PAGE = 32,
  parameter int SLOW_OSC_KHZ   = 32
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // cpu data-memory access
  input  wire logic [7:0]  cpu_sector,
  input  wire logic [7:0]  cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // slow oscillator tick, one sys_clk wide
  input  wire logic        slow_tick,
  // whole-chip reset request
  output logic             chip_reset_req,
  // flash array
  output logic             fl_req,
  output logic      [1:0]  fl_cmd,
  output logic      [15:0] fl_addr,
  output logic      [15:0] fl_wdata,
  input  wire logic        fl_ack,
  input  wire logic [15:0] fl_rdata
);
  import fspc_pkg::*;
  localparam int IDXW = $clog2(WORDS_PER_PAGE);
  localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_BITS) - 1);
  localparam logic [15:0] PAGE_MASK = ADDR_MASK & ~16'(WORDS_PER_PAGE - 1);
  localparam logic [IDXW-1:0] LAST_IDX = IDXW'(WORDS_PER_PAGE - 1);
  // RL22 RL17
  if (ADDR_BITS < 13 || ADDR_BITS > 16 ||
      !(WORDS_PER_PAGE == 32 || WORDS_PER_PAGE == 64 || WORDS_PER_PAGE == 128)) begin : g_chk
    $error("fspc_ctrl: unsupported address width or page size");
  end

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_CLR   = 4'b0010,
    S_ISSUE = 4'b0100,
    S_WAIT  = 4'b1000
  } fspc_state_t;

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n_sync;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  logic              status_reg;
  logic [2:0]        mode_reg;
  logic              proc_reg;
  logic              wstart_reg;
  logic              rpermit_reg;
  logic              rstart_reg;
  logic [7:0]        rstpat_reg;
  logic              bufclr_reg;
  logic [15:0]       addr_reg;
  logic [15:0]       page_reg;
  logic [7:0]        data_reg [0:7];
  logic [15:0]       wbuf [0:WORDS_PER_PAGE-1];
  fspc_state_t       state_reg;
  logic [IDXW-1:0]   idx_reg;
  logic [1:0]        op_reg;
  logic              unlock_done;
  logic              unlock_ok;

  // address decode; sector must match as well as the location
  logic ctl_sel;
  logic dat_sel;
  logic wr_main;
  logic wr_rstpat;
  logic wr_bufclr;
  logic wr_alo;
  logic wr_ahi;
  logic wr_dat;
  logic wr_d0hi;
  logic [2:0] dat_idx;
  logic [2:0] unlock_idx;
  assign ctl_sel   = cpu_sector == FSPC_CTRL_SECTOR;
  assign dat_sel   = cpu_sector == FSPC_DATA_SECTOR;
  assign wr_main   = cpu_wr && ctl_sel && cpu_addr == FSPC_MAIN_CTRL; // RL1
  assign wr_rstpat = cpu_wr && ctl_sel && cpu_addr == FSPC_RST_PATTERN; // RL1
  assign wr_bufclr = cpu_wr && ctl_sel && cpu_addr == FSPC_BUF_CLR_CTRL; // RL1
  assign wr_alo    = cpu_wr && dat_sel && cpu_addr == FSPC_ADDR_LO;
  assign wr_ahi    = cpu_wr && dat_sel && cpu_addr == FSPC_ADDR_HI;
  assign wr_dat    = cpu_wr && dat_sel && cpu_addr >= FSPC_DATA0_LO && cpu_addr <= FSPC_DATA3_HI;
  assign wr_d0hi   = cpu_wr && dat_sel && cpu_addr == FSPC_DATA0_HI;
  assign dat_idx   = 3'(cpu_addr - FSPC_DATA0_LO);
  assign unlock_idx = (wr_dat && cpu_addr >= FSPC_DATA1_LO) ? 3'(cpu_addr - FSPC_DATA1_LO)
                                                            : FSPC_NO_IDX;

  // completion strobes from the sequencer
  logic last_ack;
  logic fin_w;
  logic fin_r;
  logic fin_c;
  logic abort_w;
  assign last_ack = state_reg == S_WAIT && fl_ack && (op_reg != FSPC_FL_WRITE || idx_reg == LAST_IDX);
  assign abort_w  = (state_reg == S_ISSUE || state_reg == S_WAIT) && op_reg != FSPC_FL_READ && !status_reg;
  assign fin_w    = (last_ack && op_reg != FSPC_FL_READ) || abort_w;
  assign fin_r    = last_ack && op_reg == FSPC_FL_READ;
  assign fin_c    = state_reg == S_CLR && idx_reg == LAST_IDX;

  // start requests refused in idle: wrong mode, locked, or read not permitted
  logic w_go;
  logic e_go;
  logic r_go;
  logic w_drop;
  logic r_drop;
  assign w_go   = status_reg && mode_reg == FSPC_MODE_WRITE; // RL6
  assign e_go   = status_reg && mode_reg == FSPC_MODE_ERASE; // RL6
  assign r_go   = rpermit_reg && mode_reg == FSPC_MODE_READ; // RL10
  assign w_drop = state_reg == S_IDLE && !bufclr_reg && wstart_reg && !w_go && !e_go; // RL21
  assign r_drop = state_reg == S_IDLE && !bufclr_reg && !wstart_reg && rstart_reg && !r_go; // RL21

  // main control register; software writes win over hardware clears
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      status_reg  <= 1'b0;
      mode_reg    <= 3'h0;
      proc_reg    <= 1'b0;
      wstart_reg  <= 1'b0;
      rpermit_reg <= 1'b0;
      rstart_reg  <= 1'b0;
    end else begin
      if (unlock_done && unlock_ok) begin
        status_reg <= 1'b1; // RL5
      end else if (wr_main && !cpu_wdata[FSPC_STATUS_BIT]) begin
        status_reg <= 1'b0; // RL3 RL4
      end
      if (wr_main) begin
        mode_reg    <= cpu_wdata[FSPC_MODE_HI:FSPC_MODE_LO];
        rpermit_reg <= cpu_wdata[FSPC_RPERMIT_BIT];
      end
      if (wr_main) begin
        proc_reg <= cpu_wdata[FSPC_PROC_BIT];
      end else if (unlock_done) begin
        proc_reg <= 1'b0; // RL20
      end
      if (wr_main) begin
        wstart_reg <= cpu_wdata[FSPC_WSTART_BIT];
      end else if (fin_w || w_drop) begin
        wstart_reg <= 1'b0; // RL9
      end
      if (wr_main) begin
        rstart_reg <= cpu_wdata[FSPC_RSTART_BIT];
      end else if (fin_r || r_drop) begin
        rstart_reg <= 1'b0; // RL11
      end
    end
  end

  // chip reset pattern and buffer clear control
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rstpat_reg     <= FSPC_REG_RESET;
      chip_reset_req <= 1'b0;
      bufclr_reg     <= 1'b0;
    end else begin
      chip_reset_req <= wr_rstpat && cpu_wdata == FSPC_CHIP_RESET_KEY; // RL12
      if (wr_rstpat) begin
        rstpat_reg <= cpu_wdata;
      end
      if (wr_bufclr) begin
        bufclr_reg <= cpu_wdata[FSPC_BUFCLR_BIT];
      end else if (fin_c) begin
        bufclr_reg <= 1'b0; // RL13
      end
    end
  end

  // address pair; upper bits beyond the variant width stay zero
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      addr_reg <= FSPC_WORD_RESET;
      page_reg <= FSPC_WORD_RESET;
    end else if (wr_alo) begin
      addr_reg <= {addr_reg[15:8], cpu_wdata} & ADDR_MASK;
    end else if (wr_ahi) begin
      addr_reg <= {cpu_wdata, addr_reg[7:0]} & ADDR_MASK; // RL15 RL16 RL22
    end else if (wr_d0hi) begin
      page_reg <= addr_reg & PAGE_MASK;
      addr_reg <= (addr_reg + 16'h0001) & ADDR_MASK; // RL18
    end
  end

  // data register pairs; a finished read lands in the first pair
  for (genvar i = 0; i < 8; i++) begin : g_data
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
        data_reg[i] <= FSPC_REG_RESET;
      end else if (wr_dat && dat_idx == 3'(i)) begin
        data_reg[i] <= cpu_wdata;
      end else if (fin_r && i < 2) begin
        data_reg[i] <= (i == 0) ? fl_rdata[7:0] : fl_rdata[15:8]; // RL17
      end
    end
  end

  // write buffer, indexed by the low address bits; no reset on the array
  always_ff @(posedge sys_clk) begin
    if (state_reg == S_CLR) begin
      wbuf[idx_reg] <= FSPC_WORD_RESET; // RL13
    end else if (wr_d0hi) begin
      wbuf[addr_reg[IDXW-1:0]] <= {cpu_wdata, data_reg[0]}; // RL18
    end
  end

  // sequencer: buffer clear, page erase, burst write, single read
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= S_IDLE;
      idx_reg   <= '0;
      op_reg    <= FSPC_FL_WRITE;
      fl_req    <= 1'b0;
      fl_cmd    <= FSPC_FL_WRITE;
      fl_addr   <= FSPC_WORD_RESET;
      fl_wdata  <= FSPC_WORD_RESET;
    end else begin
      case (state_reg)
        S_IDLE: begin
          idx_reg <= '0;
          if (bufclr_reg) begin
            state_reg <= S_CLR;
          end else if (wstart_reg && w_go) begin
            op_reg    <= FSPC_FL_WRITE; // RL9
            state_reg <= S_ISSUE;
          end else if (wstart_reg && e_go) begin
            op_reg    <= FSPC_FL_ERASE;
            state_reg <= S_ISSUE;
          end else if (!wstart_reg && rstart_reg && r_go) begin
            op_reg    <= FSPC_FL_READ; // RL11
            state_reg <= S_ISSUE;
          end
        end
        S_CLR: begin
          idx_reg <= idx_reg + 1'b1;
          if (fin_c) begin
            state_reg <= S_IDLE;
          end
        end
        S_ISSUE: begin
          if (abort_w) begin
            state_reg <= S_IDLE; // RL3
          end else begin
            fl_req    <= 1'b1;
            fl_cmd    <= op_reg;
            state_reg <= S_WAIT;
            if (op_reg == FSPC_FL_WRITE) begin
              fl_addr  <= page_reg | {{(16-IDXW){1'b0}}, idx_reg}; // RL17
              fl_wdata <= wbuf[idx_reg];
            end else if (op_reg == FSPC_FL_ERASE) begin
              fl_addr <= addr_reg & PAGE_MASK;
            end else begin
              fl_addr <= addr_reg;
            end
          end
        end
        S_WAIT: begin
          if (abort_w) begin
            fl_req    <= 1'b0; // RL3
            state_reg <= S_IDLE;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            if (last_ack) begin
              state_reg <= S_IDLE;
            end else begin
              idx_reg   <= idx_reg + 1'b1;
              state_reg <= S_ISSUE;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          fl_req    <= 1'b0;
        end
      endcase
    end
  end

  // unlock checker starts when procedure bit and unlock mode are set, then runs until done
  fspc_unlock #(
    .SLOW_OSC_KHZ (SLOW_OSC_KHZ)
  ) u_unlock (
    .clk       (sys_clk),
    .rst_n     (rst_n_sync),
    .arm       (proc_reg && mode_reg == FSPC_MODE_UNLOCK), // RL7
    .slow_tick (slow_tick),
    .wr_stb    (wr_dat),
    .wr_idx    (unlock_idx),
    .wr_data   (cpu_wdata),
    .done      (unlock_done),
    .ok        (unlock_ok)
  );

  // registered read data; unmapped locations read zero
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cpu_rdata <= FSPC_REG_RESET;
    end else if (cpu_rd) begin
      if (ctl_sel && cpu_addr == FSPC_MAIN_CTRL) begin
        cpu_rdata <= {status_reg, mode_reg, proc_reg, wstart_reg, rpermit_reg, rstart_reg};
      end else if (ctl_sel && cpu_addr == FSPC_RST_PATTERN) begin
        cpu_rdata <= rstpat_reg;
      end else if (ctl_sel && cpu_addr == FSPC_BUF_CLR_CTRL) begin
        cpu_rdata <= {7'h00, bufclr_reg}; // RL14
      end else if (dat_sel && cpu_addr == FSPC_ADDR_LO) begin
        cpu_rdata <= addr_reg[7:0];
      end else if (dat_sel && cpu_addr == FSPC_ADDR_HI) begin
        cpu_rdata <= addr_reg[15:8];
      end else if (dat_sel && cpu_addr >= FSPC_DATA0_LO && cpu_addr <= FSPC_DATA3_HI) begin
        cpu_rdata <= data_reg[dat_idx];
      end else begin
        cpu_rdata <= FSPC_REG_RESET;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_key_write;
    wr_rstpat && cpu_wdata == FSPC_CHIP_RESET_KEY;
  endsequence
  sequence s_reset_pulse;
    chip_reset_req ##1 !chip_reset_req;
  endsequence
  property p_chip_reset;
    s_key_write |=> s_reset_pulse;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("no chip reset pulse"); // RL12

  property p_status_sw_set;
    wr_main && cpu_wdata[FSPC_STATUS_BIT] && !status_reg && !unlock_done |=> !status_reg;
  endproperty
  a_status_sw_set: assert property (p_status_sw_set) else $error("software set status"); // RL4

  property p_status_clear;
    wr_main && !cpu_wdata[FSPC_STATUS_BIT] && !(unlock_done && unlock_ok) |=> !status_reg;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // RL3

  property p_status_ok;
    unlock_done && unlock_ok |=> status_reg && !proc_reg;
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("unlock success lost"); // RL5

  property p_proc_end;
    unlock_done && !wr_main |=> !proc_reg;
  endproperty
  a_proc_end: assert property (p_proc_end) else $error("procedure bit kept"); // RL20

  property p_reserved;
    w_drop |=> state_reg == S_IDLE && !fl_req;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode started"); // RL21

  property p_read_gate;
    $rose(fl_req) && fl_cmd == FSPC_FL_READ |-> $past(rpermit_reg);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read without permit"); // RL10

  property p_addr_inc;
    wr_d0hi |=> addr_reg == (($past(addr_reg) + 16'h0001) & ADDR_MASK);
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address not incremented"); // RL18

  property p_addr_mask;
    (addr_reg & ~ADDR_MASK) == 16'h0000;
  endproperty
  a_addr_mask: assert property (p_addr_mask) else $error("address upper bits set"); // RL22

  sequence s_clear_start;
    state_reg == S_IDLE && bufclr_reg && !wr_bufclr;
  endsequence
  property p_bufclr;
    s_clear_start |-> ##[1:130] !bufclr_reg;
  endproperty
  a_bufclr: assert property (p_bufclr) else $error("buffer clear stuck"); // RL13

  property p_fc2_zero;
    cpu_rd && ctl_sel && cpu_addr == FSPC_BUF_CLR_CTRL |=> cpu_rdata[7:1] == 7'h00;
  endproperty
  a_fc2_zero: assert property (p_fc2_zero) else $error("upper bits not zero"); // RL14
endmodule

// file: fspc_flash_model.sv
// behavioural flash array answering controller requests
`timescale 1ns/1ps
module fspc_flash_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request
  input  wire logic        fl_req,
  input  wire logic [1:0]  fl_cmd,
  input  wire logic [15:0] fl_addr,
  input  wire logic [15:0] fl_wdata,
  // answer and counts
  output logic             fl_ack,
  output logic      [15:0] fl_rdata,
  output int               n_wr,
  output int               n_er,
  output int               n_rd
);
  import fspc_pkg::*;
  logic [15:0] mem [256];
  logic [2:0]  dly;
  logic        slow;
  // known contents so reads have a checkable answer
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h1000 + 16'(i);
    end
  end
  // ack after one or four cycles in turn, fast and slow replies
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_ack <= 1'b0;
      fl_rdata <= 16'ha5a5;
      dly <= 3'h0;
      slow <= 1'b0;
    end else begin
      fl_ack <= 1'b0;
      fl_rdata <= ~fl_rdata; // idle data never looks held
      if (fl_req && !fl_ack && dly != (slow ? 3'h3 : 3'h0)) begin
        dly <= dly + 3'h1;
      end else if (fl_req && !fl_ack) begin
        fl_ack <= 1'b1;
        dly <= 3'h0;
        slow <= !slow;
        if (fl_cmd == FSPC_FL_WRITE) begin
          mem[fl_addr[7:0]] <= fl_wdata;
        end
        if (fl_cmd == FSPC_FL_READ) begin
          fl_rdata <= mem[fl_addr[7:0]];
        end
        n_wr <= n_wr + int'(fl_cmd == FSPC_FL_WRITE);
        n_er <= n_er + int'(fl_cmd == FSPC_FL_ERASE);
        n_rd <= n_rd + int'(fl_cmd == FSPC_FL_READ);
      end
    end
  end
endmodule

// file: fspc_ctrl_bench.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module fspc_ctrl_bench;
  import fspc_pkg::*;
  logic        sys_clk, rst_n, cpu_wr, cpu_rd, chip_reset_req, fl_req, fl_ack;
  logic [7:0]  cpu_sector, cpu_addr, cpu_wdata, cpu_rdata, rv;
  logic [1:0]  fl_cmd;
  logic [15:0] fl_addr, fl_wdata, fl_rdata;
  logic        slow_tick = 1'b0;
  int          failures, n_tests, n_wr, n_er, n_rd, n_rst, tick_cnt;
  logic [7:0]  rdata_wide, rv_wide;
  fspc_ctrl #(.ADDR_BITS(13), .WORDS_PER_PAGE(32), .SLOW_OSC_KHZ(32)) uut (.sys_clk, .rst_n,
    .cpu_sector, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .slow_tick,
    .chip_reset_req, .fl_req, .fl_cmd, .fl_addr, .fl_wdata, .fl_ack, .fl_rdata);
  fspc_flash_model fl (.clk(sys_clk), .rst_n, .fl_req, .fl_cmd, .fl_addr, .fl_wdata,
    .fl_ack, .fl_rdata, .n_wr, .n_er, .n_rd);
  // fourteen-bit variant on the same bus; identical inputs keep it in step with uut
  fspc_ctrl #(.ADDR_BITS(14), .WORDS_PER_PAGE(32), .SLOW_OSC_KHZ(32)) uut_wide (
    .sys_clk, .rst_n, .cpu_sector, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata(rdata_wide), .slow_tick, .chip_reset_req(), .fl_req(), .fl_cmd(), .fl_addr(),
    .fl_wdata(), .fl_ack, .fl_rdata);
  // 10 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // slow tick every 20 cycles
  always @(negedge sys_clk) begin
    tick_cnt <= (tick_cnt == 19) ? 0 : tick_cnt + 1;
    slow_tick <= (tick_cnt == 19);
  end
  // count reset pulses, one cycle wide so each counts once
  always @(posedge sys_clk) begin
    if (chip_reset_req === 1'b1) begin
      n_rst <= n_rst + 1;
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access; idle cycle first so strobes never change twice at one edge
  task automatic acc(input logic w, input logic [7:0] s, a, d);
    @(negedge sys_clk);
    cpu_sector = s;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = !w;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    rv = cpu_rdata;
    rv_wide = rdata_wide;
  endtask
  task automatic rc(input logic [7:0] s, a, e);
    acc(1'b0, s, a, 8'h0);
    chk({8'h0, rv}, {8'h0, e});
  endtask
  task automatic poll(input logic [7:0] s, a, m);
    for (int i = 0; i < 300; i++) begin
      acc(1'b0, s, a, 8'h0);
      if ((rv & m) === 8'h0) begin
        break;
      end
    end
  endtask
  task automatic t_regs;
    rc(8'h1, 8'h43, 8'h0);
    acc(1'b1, 8'h1, 8'h50, 8'hff);
    rc(8'h1, 8'h50, 8'h0);
    acc(1'b1, 8'h1, 8'h43, 8'h80);
    rc(8'h1, 8'h43, 8'h0);
    acc(1'b1, 8'h0, 8'h41, 8'hff);
    rc(8'h0, 8'h41, 8'h1f);
    chk({8'h0, rv_wide}, 16'h003f);
    acc(1'b1, 8'h0, 8'h41, 8'h0);
    acc(1'b1, 8'h1, 8'h45, 8'hff);
    poll(8'h1, 8'h45, 8'h1);
    rc(8'h1, 8'h45, 8'h0);
  endtask
  task automatic t_key;
    int r;
    r = n_rst;
    acc(1'b1, 8'h1, 8'h44, 8'h54);
    repeat (2) @(negedge sys_clk);
    chk(16'(n_rst - r), 16'h0);
    acc(1'b1, 8'h1, 8'h44, 8'h55);
    repeat (2) @(negedge sys_clk);
    chk(16'(n_rst - r), 16'h1);
  endtask
  task automatic t_read;
    int r;
    r = n_rd;
    acc(1'b1, 8'h0, 8'h40, 8'h05);
    acc(1'b1, 8'h1, 8'h43, 8'h31);
    repeat (6) @(negedge sys_clk);
    rc(8'h1, 8'h43, 8'h30);
    chk(16'(n_rd - r), 16'h0);
    acc(1'b1, 8'h1, 8'h43, 8'h33);
    poll(8'h1, 8'h43, 8'h1);
    chk(16'(n_rd - r), 16'h1);
    rc(8'h0, 8'h42, 8'h05);
    rc(8'h0, 8'h43, 8'h10);
    rc(8'h0, 8'h40, 8'h05);
  endtask
  task automatic unlock(input logic [7:0] bad);
    acc(1'b1, 8'h1, 8'h43, 8'h68);
    for (int i = 0; i < FSPC_UNLOCK_LEN; i++) begin
      acc(1'b1, 8'h0, 8'h44 + 8'(i), FSPC_UNLOCK_PAT[i] ^ ((i == 3) ? bad : 8'h0));
    end
  endtask
  task automatic t_unlock;
    unlock(8'h1);
    rc(8'h1, 8'h43, 8'h60);
    acc(1'b1, 8'h1, 8'h43, 8'h68);
    repeat (220) @(negedge sys_clk);
    rc(8'h1, 8'h43, 8'h60);
    unlock(8'h0);
    rc(8'h1, 8'h43, 8'he0);
  endtask
  task automatic t_reserved;
    logic [2:0] codes [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
    int s;
    s = n_wr + n_er + n_rd;
    foreach (codes[i]) begin
      acc(1'b1, 8'h1, 8'h43, {1'b1, codes[i], 4'h7});
      repeat (6) @(negedge sys_clk);
      rc(8'h1, 8'h43, {1'b1, codes[i], 4'h2});
    end
    chk(16'(n_wr + n_er + n_rd - s), 16'h0);
  endtask
  task automatic t_write;
    int w;
    int e;
    w = n_wr;
    e = n_er;
    acc(1'b1, 8'h1, 8'h45, 8'h1);
    poll(8'h1, 8'h45, 8'h1);
    acc(1'b1, 8'h0, 8'h40, 8'h40);
    for (int i = 0; i < 32; i++) begin
      acc(1'b1, 8'h0, 8'h42, 8'(i));
      acc(1'b1, 8'h0, 8'h43, 8'h20);
    end
    rc(8'h0, 8'h40, 8'h60);
    acc(1'b1, 8'h1, 8'h43, 8'h94);
    poll(8'h1, 8'h43, 8'h4);
    chk(16'(n_er - e), 16'h1);
    acc(1'b1, 8'h1, 8'h43, 8'h84);
    poll(8'h1, 8'h43, 8'h4);
    chk(16'(n_wr - w), 16'h20);
    chk(fl.mem[8'h5f], 16'h201f);
    acc(1'b1, 8'h1, 8'h43, 8'h04);
    repeat (6) @(negedge sys_clk);
    rc(8'h1, 8'h43, 8'h0);
    chk(16'(n_wr - w), 16'h20);
    // clearing status in mid-burst must cut the burst short
    unlock(8'h0);
    acc(1'b1, 8'h1, 8'h43, 8'h84);
    acc(1'b1, 8'h1, 8'h43, 8'h04);
    repeat (200) @(negedge sys_clk);
    rc(8'h1, 8'h43, 8'h0);
    chk(16'((n_wr - w) < 40), 16'h1);
  endtask
  task automatic end_sim;
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    cpu_sector = 8'h0;
    cpu_addr = 8'h0;
    cpu_wdata = 8'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_regs;
    t_key;
    t_read;
    t_unlock;
    t_reserved;
    t_write;
    end_sim;
  end
  // watchdog at 50000 cycles, far beyond the thousand or so cycles the run needs
  initial begin
    #5_000_000;
    failures++;
    end_sim;
  end
endmodule
